// >>> pic_csr_pkg.sv
// Purpose: shared constants and carrier types for the interrupt claim and threshold registers
// Assumes: 12-bit register numbers on the core's register port, 32-bit data
// Notes:   priority fields are kept internally in standard order (15 highest)
package pic_csr_pkg;

  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 12;
  localparam int          PRI_W         = 4;
  localparam int          ID_W          = 8;
  localparam int          NUM_SRC       = 255;

  // register numbers
  localparam logic [11:0] VECTOR_TABLE_BASE_ADDR       = 12'hbc8;
  localparam logic [11:0] PRIORITY_THRESHOLD_ADDR      = 12'hbc9;
  localparam logic [11:0] CLAIM_CAPTURE_TRIGGER_ADDR   = 12'hbca;
  localparam logic [11:0] CLAIMED_SOURCE_PRIORITY_ADDR = 12'hbcb;
  localparam logic [11:0] NESTING_PRIORITY_LEVEL_ADDR  = 12'hbcc;
  localparam logic [11:0] HANDLER_ADDRESS_POINTER_ADDR = 12'hfc8;

  // field layout
  localparam int          BASE_LSB      = 10;
  localparam int          BASE_W        = 22;
  localparam int          CLAIM_ID_LSB  = 2;
  localparam int          PRI_LSB       = 0;

  // reset values
  localparam logic [21:0] BASE_RESET    = 22'h000000;
  localparam logic [3:0]  PRI_RESET     = 4'h0;
  localparam logic [7:0]  ID_RESET      = 8'h00;
  localparam logic [31:0] DATA_ZERO     = 32'h00000000;

  // one request on the core's register port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_type;

  // the currently winning source
  typedef struct packed {
    logic [7:0] id;
    logic [3:0] pri;
  } winner_type;

endpackage

// >>> pic_claim_threshold_csrs.sv
// Purpose: claim, threshold and nesting registers of the external interrupt controller
// Assumes: one register access per cycle; source priorities arrive in standard order
// Notes:   all outputs are registered, read data follows a read by one cycle;
//          the winner is found by a balanced tree of pairwise picks, so the
//          compare depth grows with the log of the source count, not the count;
//          notify follows a source change by two cycles, a register write also by two
//
// Operation
// - notify the core only when winner priority exceeds the global threshold
// - threshold in bits 3:0; standard order 0 masks none, 15 masks all
// - reverse order: 15 masks none, 0 masks all, ranking reversed
// - threshold, claimed and current priority accesses inverted in reverse order
// - vector base writable in bits 31:10, bits 9:0 read zero
// - handler pointer base is not stored; it mirrors the vector base
// - pointer holds captured id in 9:2, 1:0 zero; ties go to lowest id
// - winning pending enabled source and its level are evaluated continuously
// - any trigger write latches winner id and its priority together
// - trigger accepts any value, reads zero, has no storage
// - with fast redirect the trigger address is invalid; hardware captures
// - claimed priority is read/write in bits 3:0, bits 31:4 read zero
// - notify only above both threshold and current nesting level
// - nesting level changes only on software writes
// - pointer at 0xfc8 is read-only; other five registers are read/write
// - threshold at 0xbc9; field and reserved bits reset to zero
// - order bit clear selects standard ranking, set selects reversed ranking
module pic_claim_threshold_csrs #(
  parameter int NUM_SRC       = pic_csr_pkg::NUM_SRC,
  parameter bit FAST_REDIRECT = 1'b0
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire pic_csr_pkg::csr_req_type csr_req,
  input  wire logic                     priority_reverse,
  input  wire logic [NUM_SRC:1]         src_pending,
  input  wire logic [NUM_SRC:1]         src_enable,
  input  wire logic [4*NUM_SRC-1:0]     src_priority,
  input  wire logic                     hw_capture,
  output logic      [31:0]              csr_rdata,
  output logic                          csr_rvalid,
  output logic                          csr_invalid,
  output logic                          ext_irq,
  output logic      [7:0]               winner_id,
  output logic      [3:0]               winner_pri
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [21:0] vt_base;
    logic [3:0]  thresh;
    logic [3:0]  claimed_pri;
    logic [3:0]  nest_pri;
    logic [7:0]  claim_id;
    logic [7:0]  win_id;
    logic [3:0]  win_pri;
    logic [31:0] rdata;
    logic        rvalid;
    logic        invalid;
    logic        irq;
  } state_type;

  state_type state;
  state_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // maps between the software view and the stored standard-order value
  // order bit selects ranking
  function automatic logic [3:0] order_map(input logic [3:0] value, input logic rev);
    order_map = rev ? ~value : value;
  endfunction

  // software view of a priority field: order applied, reserved bits zero
  function automatic logic [31:0] pri_word(input logic [3:0] value, input logic rev);
    pri_word = {28'h0000000, order_map(value, rev)};
  endfunction

  // both thresholds are strict, so an equal level never preempts
  function automatic logic notify(input logic [3:0] pri,
                                  input logic [3:0] thresh,
                                  input logic [3:0] nest);
    notify = (pri > thresh) && (pri > nest);
  endfunction

  // a source that is not pending and enabled, or sits at level 0, is no candidate;
  // it carries id 0 so that an empty subtree reports no winner
  function automatic pic_csr_pkg::winner_type leaf(input logic       live,
                                                   input logic [3:0] pri,
                                                   input logic [7:0] id);
    leaf = '0;
    if (live && (pri != pic_csr_pkg::PRI_RESET)) begin
      leaf.id  = id;
      leaf.pri = pri;
    end
  endfunction

  // only a strictly higher level in the upper half replaces the lower half
  function automatic pic_csr_pkg::winner_type pick(input pic_csr_pkg::winner_type lo,
                                                   input pic_csr_pkg::winner_type hi);
    pick = (hi.pri > lo.pri) ? hi : lo;
  endfunction

  // one strobe per implemented register
  typedef struct packed {
    logic base;
    logic thresh;
    logic trigger;
    logic claimed;
    logic nest;
    logic pointer;
  } hit_type;

  function automatic hit_type decode(input logic [11:0] addr);
    decode         = '0;
    decode.base    = (addr == pic_csr_pkg::VECTOR_TABLE_BASE_ADDR);
    decode.thresh  = (addr == pic_csr_pkg::PRIORITY_THRESHOLD_ADDR);
    decode.trigger = (addr == pic_csr_pkg::CLAIM_CAPTURE_TRIGGER_ADDR) && !FAST_REDIRECT;
    decode.claimed = (addr == pic_csr_pkg::CLAIMED_SOURCE_PRIORITY_ADDR);
    decode.nest    = (addr == pic_csr_pkg::NESTING_PRIORITY_LEVEL_ADDR);
    decode.pointer = (addr == pic_csr_pkg::HANDLER_ADDRESS_POINTER_ADDR);
  endfunction

  // is a register number implemented in this build
  function automatic logic addr_valid(input logic [11:0] addr);
    hit_type hits;
    hits       = decode(addr);
    addr_valid = |hits;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // winner tree

  // leaves are padded to a power of two; leaf k stands for source id k
  localparam int LEVELS = $clog2(NUM_SRC + 1);
  localparam int LEAVES = 1 << LEVELS;

  pic_csr_pkg::winner_type node [1:2*LEAVES-1];

  genvar g;
  generate
    for (g = 0; g < LEAVES; g = g + 1) begin : g_leaf
      if (g >= 1 && g <= NUM_SRC) begin : g_src
        assign node[LEAVES+g] = leaf(src_pending[g] && src_enable[g],
                                     src_priority[4*(g-1) +: 4], 8'(g));
      end else begin : g_pad
        // id 0 and padding leaves never win
        assign node[LEAVES+g] = '0;
      end
    end
  endgenerate

  genvar h;
  generate
    for (h = 1; h < LEAVES; h = h + 1) begin : g_pick
      assign node[h] = pick(node[2*h], node[2*h+1]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state

  pic_csr_pkg::winner_type best;
  logic                    req_ok;
  logic                    do_capture;
  logic [31:0]             pointer;

  always_comb begin
    next_state = state;

    // tree root is the lowest id at the highest level
    best = node[1];
    next_state.win_id  = best.id;
    next_state.win_pri = best.pri;

    // and above nesting level
    // uses the registered winner, which keeps the long compare path short
    next_state.irq = notify(state.win_pri, state.thresh, state.nest_pri);

    req_ok = addr_valid(csr_req.addr);

    // base field taken live from the vector base
    // id in 9:2, low two bits zero
    pointer = {state.vt_base, state.claim_id, 2'b00};

    if (FAST_REDIRECT) begin
      do_capture = hw_capture;
    end else begin
      do_capture = csr_req.wr && (csr_req.addr == pic_csr_pkg::CLAIM_CAPTURE_TRIGGER_ADDR);
    end

    // register writes
    if (csr_req.wr && req_ok) begin
      case (csr_req.addr)
        pic_csr_pkg::VECTOR_TABLE_BASE_ADDR: begin
          next_state.vt_base = csr_req.wdata[31:pic_csr_pkg::BASE_LSB];
        end
        pic_csr_pkg::PRIORITY_THRESHOLD_ADDR: begin
          // reverse value kept in standard form
          next_state.thresh = order_map(csr_req.wdata[3:0], priority_reverse);
        end
        pic_csr_pkg::CLAIMED_SOURCE_PRIORITY_ADDR: begin
          // software may rewrite the claimed level
          next_state.claimed_pri = order_map(csr_req.wdata[3:0], priority_reverse);
        end
        pic_csr_pkg::NESTING_PRIORITY_LEVEL_ADDR: begin
          next_state.nest_pri = order_map(csr_req.wdata[3:0], priority_reverse);
        end
        default: begin
          next_state.vt_base = state.vt_base;
        end
      endcase
    end

    // id and level captured together
    // capture wins over a same-cycle software write of the claimed level
    if (do_capture) begin
      next_state.claim_id    = state.win_id;
      next_state.claimed_pri = state.win_pri;
    end

    // register reads, answered one cycle later
    next_state.rvalid  = csr_req.rd && req_ok;
    next_state.invalid = (csr_req.rd || csr_req.wr) && !req_ok;
    next_state.rdata   = pic_csr_pkg::DATA_ZERO;
    if (csr_req.rd && req_ok) begin
      case (csr_req.addr)
        pic_csr_pkg::VECTOR_TABLE_BASE_ADDR: begin
          next_state.rdata = {state.vt_base, 10'h000};
        end
        pic_csr_pkg::PRIORITY_THRESHOLD_ADDR: begin
          next_state.rdata = pri_word(state.thresh, priority_reverse);
        end
        pic_csr_pkg::CLAIMED_SOURCE_PRIORITY_ADDR: begin
          next_state.rdata = pri_word(state.claimed_pri, priority_reverse);
        end
        pic_csr_pkg::NESTING_PRIORITY_LEVEL_ADDR: begin
          next_state.rdata = pri_word(state.nest_pri, priority_reverse);
        end
        pic_csr_pkg::HANDLER_ADDRESS_POINTER_ADDR: begin
          next_state.rdata = pointer;
        end
        default: begin
          next_state.rdata = pic_csr_pkg::DATA_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state.vt_base     <= pic_csr_pkg::BASE_RESET;
      state.thresh      <= pic_csr_pkg::PRI_RESET;
      state.claimed_pri <= pic_csr_pkg::PRI_RESET;
      state.nest_pri    <= pic_csr_pkg::PRI_RESET;
      state.claim_id    <= pic_csr_pkg::ID_RESET;
      state.win_id      <= pic_csr_pkg::ID_RESET;
      state.win_pri     <= pic_csr_pkg::PRI_RESET;
      state.rdata       <= pic_csr_pkg::DATA_ZERO;
      state.rvalid      <= 1'b0;
      state.invalid     <= 1'b0;
      state.irq         <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop

  assign csr_rdata   = state.rdata;
  assign csr_rvalid  = state.rvalid;
  assign csr_invalid = state.invalid;
  assign ext_irq     = state.irq;
  assign winner_id   = state.win_id;
  assign winner_pri  = state.win_pri;

endmodule

// >>> pic_core_model.sv
// Purpose: core side of the register port, one access in flight
// Assumes: answer stands one cycle, one cycle after the request is taken
// Notes:   released write data turns to its inverse so stale data never matches
module pic_core_model (
  input  wire logic                     mclk,
  input  wire logic [31:0]              csr_rdata,
  input  wire logic                     csr_invalid,
  output pic_csr_pkg::csr_req_type      csr_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial csr_req = '0;
  task automatic access(input logic w, r, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic inv);
    csr_req <= '{w, r, a, d};
    @(posedge mclk);
    csr_req <= '{1'b0, 1'b0, a, ~d};
    @(posedge mclk);
    q = csr_rdata;
    inv = csr_invalid;
  endtask
  // a write, then a read taken on the very next edge
  task automatic write_read(input logic [11:0] wa, input logic [31:0] wd, input logic [11:0] ra,
                            output logic [31:0] q, output logic inv);
    csr_req <= '{1'b1, 1'b0, wa, wd};
    @(posedge mclk);
    access(1'b0, 1'b1, ra, ~wd, q, inv);
  endtask
  task automatic handler_entry(output logic [31:0] lvl);
    logic [31:0] t;
    logic        v;
    access(1'b0, 1'b1, 12'hbcb, 32'h0, lvl, v);
    access(1'b1, 1'b0, 12'hbcc, lvl, t, v);
  endtask
endmodule

// >>> pic_claim_threshold_csrs_assertions.sv
// Purpose: port checks of the claim and threshold registers
// Assumes: fast redirect left out
// Notes:   answers land one cycle after a request is taken
module pic_csr_checker #(
  parameter int NUM_SRC = 8
) (
  input wire logic                     mclk,
  input wire logic                     sys_rst,
  input wire pic_csr_pkg::csr_req_type csr_req,
  input wire logic                     priority_reverse,
  input wire logic [NUM_SRC:1]         src_pending,
  input wire logic [NUM_SRC:1]         src_enable,
  input wire logic [4*NUM_SRC-1:0]     src_priority,
  input wire logic                     hw_capture,
  input wire logic [31:0]              csr_rdata,
  input wire logic                     csr_rvalid,
  input wire logic                     csr_invalid,
  input wire logic                     ext_irq,
  input wire logic [7:0]               winner_id,
  input wire logic [3:0]               winner_pri
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [11:0] a;
  logic [3:0]  wlo;
  logic        ok;
  assign a   = csr_req.addr;
  assign wlo = csr_req.wdata[3:0];
  assign ok  = a inside {12'hbc8, 12'hbc9, 12'hbca, 12'hbcb, 12'hbcc, 12'hfc8};
  sequence s_rd(n);
    csr_req.rd && !csr_req.wr && a == n;
  endsequence
  sequence s_wr(n);
    csr_req.wr && !csr_req.rd && a == n;
  endsequence
  a_read_answered: assert property (csr_req.rd && ok |=> csr_rvalid)
    else $error("read not answered");
  a_bad_number: assert property ((csr_req.rd || csr_req.wr) && !ok |=> csr_invalid)
    else $error("unmapped not flagged");
  a_trigger_zero: assert property (s_rd(12'hbca) |=> csr_rdata == 32'h0)
    else $error("trigger read not zero");
  a_base_low_zero: assert property (s_rd(12'hbc8) |=> csr_rdata[9:0] == 10'h0)
    else $error("base low bits set");
  a_upper_zero: assert property (
    csr_req.rd && a > 12'hbca && a < 12'hbcd |=> csr_rdata[31:4] == 28'h0)
    else $error("upper bits set");
  a_notify_cause: assert property (ext_irq |-> $past(winner_pri) != 4'h0)
    else $error("notify without winner");
  a_idle_winner: assert property (winner_pri == 4'h0 |-> winner_id == 8'h00)
    else $error("winner id without level");
  a_thresh_round: assert property (
    s_wr(12'hbc9) ##1 s_rd(12'hbc9) ##0 $stable(priority_reverse)
    |=> csr_rdata[3:0] == $past(wlo, 2))
    else $error("threshold readback differs");
  a_claim_pair: assert property (
    csr_req.wr && a == 12'hbca ##1 s_rd(12'hfc8) |=> csr_rdata[9:2] == $past(winner_id, 2))
    else $error("claim id not captured");
endmodule
bind pic_claim_threshold_csrs pic_csr_checker #(.NUM_SRC(NUM_SRC)) checker_inst (.*);

// >>> pic_claim_threshold_csrs_tb_top.sv
// Purpose: random and corner runs of the claim and threshold registers
// Assumes: eight sources; fast redirect left out, so hw_capture stays low
// Notes:   expected winner comes from a bench function, expected notify from an inline compare
module pic_claim_threshold_csrs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 8;
  logic                     mclk, sys_rst, rev, inv, irq, iv;
  logic [N:1]               pend, en;
  logic [31:0]              pri, rdata, q, d;
  logic [11:0]              w;
  logic [7:0]               wid;
  logic [3:0]               wpri, thr, cur, wexp;
  logic [11:0]              regs [6] = '{12'hbc8, 12'hbc9, 12'hbca, 12'hbcb, 12'hbcc, 12'hfc8};
  pic_csr_pkg::csr_req_type req;
  int                       err_count, cmp_count, seed;
  pic_core_model core (.mclk(mclk), .csr_rdata(rdata), .csr_invalid(inv), .csr_req(req));
  pic_claim_threshold_csrs #(.NUM_SRC(N)) dut (.mclk(mclk), .sys_rst(sys_rst), .csr_req(req),
    .priority_reverse(rev), .src_pending(pend), .src_enable(en), .src_priority(pri),
    .hw_capture(1'b0), .csr_rdata(rdata), .csr_rvalid(), .csr_invalid(inv),
    .ext_irq(irq), .winner_id(wid), .winner_pri(wpri));
  // lowest id kept on a tie because only a strictly higher level replaces it
  function automatic logic [11:0] best(input logic [N:1] p, e, input logic [31:0] pr);
    best = 12'h000;
    for (int s = 1; s <= N; s++)
      if (p[s] && e[s] && pr[4*(s-1)+:4] > best[3:0]) best = {8'(s), pr[4*(s-1)+:4]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pair(input logic [11:0] wa, input logic [31:0] wd, input logic [11:0] ra);
    core.write_read(wa, wd, ra, q, iv);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    seed = 48890;
    cur = 4'h0;
    {sys_rst, rev, pend, en, pri} = {1'b1, 49'h0};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (regs[k]) begin
      core.access(1'b0, 1'b1, regs[k], 32'h0, q, iv);
      check("reset", q, 32'h0);
    end
    core.access(1'b1, 1'b1, 12'hbcd, 32'h0000000f, q, iv);
    check("unmapped flag", {31'h0, iv}, 32'h1);
    check("unmapped data", q, 32'h0);
    d = $random(seed);
    core.access(1'b1, 1'b0, 12'hbc8, d, q, iv);
    core.access(1'b1, 1'b0, 12'hfc8, ~d, q, iv);
    core.access(1'b0, 1'b1, 12'hbc8, 32'h0, q, iv);
    check("base", q, d & 32'hfffffc00);
    core.access(1'b0, 1'b1, 12'hfc8, 32'h0, q, iv);
    check("pointer", q, d & 32'hfffffc00);
    for (int i = 0; i < 24; i++) begin
      rev <= i[1];
      pend <= 8'($random(seed));
      en <= 8'($random(seed));
      pri <= $random(seed);
      wexp = (i < 4) ? {4{i[0]}} : 4'($random(seed));
      @(posedge mclk);
      pair(12'hbc9, {28'h0, wexp}, 12'hbc9);
      check("thresh", q, {28'h0, wexp});
      thr = rev ? ~wexp : wexp;
      repeat (2) @(posedge mclk);
      w = best(pend, en, pri);
      check("winner", {20'h0, wid, wpri}, {20'h0, w});
      check("notify", {31'h0, irq}, {31'h0, w[3:0] > thr && w[3:0] > cur});
      pair(12'hbca, 32'h0, 12'hfc8);
      check("claim id", q, (d & 32'hfffffc00) | {22'h0, w[11:4], 2'b00});
      if (i[0]) begin
        core.handler_entry(q);
        check("claim pri", q, {28'h0, rev ? ~w[3:0] : w[3:0]});
        core.access(1'b0, 1'b1, 12'hbcc, 32'h0, q, iv);
        check("nesting", q, {28'h0, rev ? ~w[3:0] : w[3:0]});
        cur = w[3:0];
      end else begin
        core.access(1'b1, 1'b0, 12'hbcc, {28'h0, {4{rev}}}, q, iv);
        cur = 4'h0;
      end
    end
    report_and_stop();
  end
endmodule
